/* hdl/lsp_buf.sv */
/*
 * lsp_buf: two-entry valid/ready buffer for received payload words.
 * Assumes both sides run on clk_in; rst_in synchronous active high.
 */
`timescale 1ns/1ns
module lsp_buf
	import lsp_pkg::*;
(
	input  wire logic      clk_in,    // system clock
	input  wire logic      rst_in,    // synchronous reset
	input  wire logic      s_valid_in, // word offered
	input  wire lsp_word_t s_word_in,  // offered word
	output logic           s_ready_out, // room available
	output logic           m_valid_out, // word available
	output lsp_word_t      m_word_out,  // oldest word
	input  wire logic      m_ready_in   // receiver takes word
);
	lsp_word_t  mem [BUF_DEPTH];
	logic       wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [1:0] count, next_count;
	logic       push, pop;

	// ---------------------------------------------------------------
	// pointer and occupancy next state
	// ---------------------------------------------------------------
	always_comb begin
		s_ready_out = (count != 2'h2);
		m_valid_out = (count != 2'h0);
		m_word_out  = mem[rd_ptr];
		push        = s_valid_in && s_ready_out;
		pop         = m_valid_out && m_ready_in;
		next_wr_ptr = push ? ~wr_ptr : wr_ptr;
		next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
		next_count  = count + {1'b0, push} - {1'b0, pop};
	end

	// registers of the buffer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
		if (push)
			mem[wr_ptr] <= s_word_in;
	end

	a_buf_no_overflow: assert property (@(posedge clk_in) disable iff (rst_in)
		count == 2'h2 && s_valid_in && !m_ready_in |=> count == 2'h2 && $stable(wr_ptr))
		else $error("buffer accepts when full");
endmodule // lsp_buf

/* hdl/lsp_pkg.sv */
/*
 * lsp_pkg: shared constants and carrier types of the lcd driver serial slave port.
 * Assumes a single 10 MHz system clock; link pins are sampled by that clock.
 */
package lsp_pkg;
	// ---------------------------------------------------------------
	// selection byte layout
	// ---------------------------------------------------------------
	localparam int         SEL_DIR_BIT   = 7;
	localparam int         SEL_UNIT_HI   = 6;
	localparam int         SEL_UNIT_LO   = 5;
	localparam logic [1:0] UNIT_MATCH    = 2'h1;
	// ---------------------------------------------------------------
	// control byte layout
	// ---------------------------------------------------------------
	localparam int         CTL_MORE_BIT  = 7;
	localparam int         CTL_TARGET_BIT = 6;
	// ---------------------------------------------------------------
	// counts and reset values
	// ---------------------------------------------------------------
	localparam int         BYTE_BITS     = 8;
	localparam logic [2:0] BIT_CNT_LAST  = 3'h7;
	localparam logic [2:0] BIT_CNT_RST   = 3'h0;
	localparam logic [7:0] BYTE_RST      = 8'h00;
	localparam int         BUF_DEPTH     = 2;

	// payload word handed to the display/command logic
	typedef struct packed {
		logic       payload_target_select; // 0 command, 1 display memory
		logic [7:0] data;
	} lsp_word_t;

	// access state, one-hot
	typedef enum logic [4:0] {
		LSP_SELECT  = 5'b00001,
		LSP_CONTROL = 5'b00010,
		LSP_PAYLOAD = 5'b00100,
		LSP_READ    = 5'b01000,
		LSP_IGNORE  = 5'b10000
	} lsp_state_t;
endpackage

/* hdl/lsp_port.sv */
/*
 * lsp_port: three-wire serial slave port of an lcd driver.
 * Assumes chip select, serial clock and data arrive asynchronously and are
 * sampled by clk_in (10 MHz); serial clock is far slower than clk_in.
 */
// Overview of operation
// - chip select high holds the serial logic in reset
// - incoming bits are captured on serial clock rising edges
// - read data changes on serial clock falling edges
// - eight-bit units, most significant bit first both ways
// - first byte after chip select falls is the selection byte
// - selection bit 7: zero write, one read
// - act only when selection bits 6..5 equal 01, else ignore transfer
// - in writes, byte after selection is a control byte
// - host reads temperature by sending selection byte with direction one
// - on reads, drive data line right after last selection bit
// - chip select rising ends a read and releases the data line
// - control bit 7 more controls follow, bit 6 selects command or display
`timescale 1ns/1ns
module lsp_port
	import lsp_pkg::*;
(
	input  wire logic       clk_in,            // system clock, 10 MHz
	input  wire logic       rst_in,            // synchronous reset, active high
	input  wire logic       chip_sel_n_in,     // chip select pin, active low
	input  wire logic       sclk_in,           // serial clock pin
	input  wire logic       sdio_in,           // shared data line, input side
	output logic            sdio_out,          // shared data line, driven value
	output logic            sdio_oe_n_out,     // low while the port drives the line
	input  wire logic [7:0] temperature_byte_in, // temperature value to return
	output logic            word_valid_out,    // payload word available
	output lsp_word_t       word_out,          // payload word and its target
	input  wire logic       word_ready_in,     // receiver takes word
	output logic            access_active_out, // selected access in progress
	output logic            overrun_out        // word dropped for lack of room
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] cs_sync, sck_sync, sd_sync;
	logic       cs_n, sck, sd, sck_prev;
	logic       rise, fall, deselect;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cs_sync  <= 2'h3;
			sck_sync <= 2'h0;
			sd_sync  <= 2'h0;
			sck_prev <= 1'b0;
		end else begin
			cs_sync  <= {cs_sync[0], chip_sel_n_in};
			sck_sync <= {sck_sync[0], sclk_in};
			sd_sync  <= {sd_sync[0], sdio_in};
			sck_prev <= sck;
		end
	end

	// edge detection on synchronised levels only
	assign cs_n     = cs_sync[1];
	assign sck      = sck_sync[1];
	assign sd       = sd_sync[1];
	assign rise     = sck && !sck_prev && !cs_n;
	assign fall     = !sck && sck_prev && !cs_n;
	assign deselect = rst_in || cs_n;

	// ---------------------------------------------------------------
	// access state machine
	// ---------------------------------------------------------------
	lsp_state_t state, next_state;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] tx, next_tx;
	logic       target, next_target;
	logic       more, next_more;
	logic       drive, next_drive;
	logic       dout, next_dout;
	logic       ovr, next_ovr;
	logic       push, next_push;
	lsp_word_t  pword, next_pword;
	logic       buf_ready;
	logic [7:0] rx_byte;

	assign rx_byte = {shreg[6:0], sd}; // msb first

	// next values of the port state
	always_comb begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_tx      = tx;
		next_target  = target;
		next_more    = more;
		next_drive   = drive;
		next_dout    = dout;
		next_ovr     = ovr;
		next_push    = 1'b0;
		next_pword   = pword;
		if (rise && state != LSP_READ && state != LSP_IGNORE) begin
			next_shreg   = rx_byte;
			next_bit_cnt = bit_cnt + 3'h1;
			if (bit_cnt == BIT_CNT_LAST) begin
				case (state)
					LSP_SELECT: begin
						if (rx_byte[SEL_UNIT_HI:SEL_UNIT_LO] != UNIT_MATCH)
							next_state = LSP_IGNORE;
						else if (rx_byte[SEL_DIR_BIT]) begin
							next_state = LSP_READ;
							next_drive = 1'b1;
							next_dout  = temperature_byte_in[BYTE_BITS-1];
							next_tx    = {temperature_byte_in[6:0], 1'b0};
						end else
							next_state = LSP_CONTROL;
					end
					LSP_CONTROL: begin
						next_more   = rx_byte[CTL_MORE_BIT];
						next_target = rx_byte[CTL_TARGET_BIT];
						next_state  = LSP_PAYLOAD;
					end
					LSP_PAYLOAD: begin
						if (more)
							next_state = LSP_CONTROL;
						next_pword = '{payload_target_select: target, data: rx_byte};
						next_push  = 1'b1;
					end
					default: next_state = LSP_IGNORE;
				endcase
			end
		end
		if (state == LSP_PAYLOAD && more && rise && bit_cnt == BIT_CNT_LAST) begin
			// a control byte with more set precedes one payload byte, then control again
			next_more = more;
		end
		if (state == LSP_READ && fall) begin
			if (bit_cnt == BIT_CNT_LAST)
				next_drive = 1'b0;
			else begin
				next_dout    = tx[BYTE_BITS-1];
				next_tx      = {tx[6:0], 1'b0};
				next_bit_cnt = bit_cnt + 3'h1;
			end
		end
		if (state == LSP_READ && rise && !drive)
			next_state = LSP_IGNORE;
		// a registered push that meets a full buffer loses its word
		if (push && !buf_ready)
			next_ovr = 1'b1;
		if (deselect) begin
			next_state   = LSP_SELECT;
			next_bit_cnt = BIT_CNT_RST;
			next_shreg   = BYTE_RST;
			next_tx      = BYTE_RST;
			next_more    = 1'b0;
			next_target  = 1'b0;
			next_drive   = 1'b0;
			next_dout    = 1'b0;
			next_push    = 1'b0;
		end
		if (rst_in)
			next_ovr = 1'b0;
	end

	// registers of the port state
	always_ff @(posedge clk_in) begin
		state   <= next_state;
		bit_cnt <= next_bit_cnt;
		shreg   <= next_shreg;
		tx      <= next_tx;
		target  <= next_target;
		more    <= next_more;
		drive   <= next_drive;
		dout    <= next_dout;
		ovr     <= next_ovr;
		push    <= next_push;
		pword   <= next_pword;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign sdio_out          = dout;
	assign sdio_oe_n_out     = !drive;
	assign access_active_out = (state != LSP_SELECT) && (state != LSP_IGNORE);
	assign overrun_out       = ovr;

	lsp_buf u_buf (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.s_valid_in  (push),
		.s_word_in   (pword),
		.s_ready_out (buf_ready),
		.m_valid_out (word_valid_out),
		.m_word_out  (word_out),
		.m_ready_in  (word_ready_in)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_deselected;
		cs_n;
	endsequence

	a_cs_resets_port: assert property (@(posedge clk_in) disable iff (rst_in)
		s_deselected |=> state == LSP_SELECT && bit_cnt == BIT_CNT_RST)
		else $error("port not reset while deselected");
	a_cs_releases_line: assert property (@(posedge clk_in) disable iff (rst_in)
		s_deselected |=> sdio_oe_n_out) else $error("line driven while deselected");
	a_bad_unit_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
		state == LSP_IGNORE |-> sdio_oe_n_out && !next_push)
		else $error("ignored access has effect");
	a_read_drives_now: assert property (@(posedge clk_in) disable iff (rst_in)
		state == LSP_SELECT && rise && bit_cnt == BIT_CNT_LAST && rx_byte[SEL_DIR_BIT]
		&& rx_byte[SEL_UNIT_HI:SEL_UNIT_LO] == UNIT_MATCH |=> !sdio_oe_n_out)
		else $error("read did not drive line");
	a_read_starts_msb: assert property (@(posedge clk_in) disable iff (rst_in)
		$past(state) == LSP_SELECT && state == LSP_READ |-> !sdio_oe_n_out
		&& sdio_out == $past(temperature_byte_in[7])) else $error("read msb wrong");
	a_out_on_fall: assert property (@(posedge clk_in) disable iff (rst_in)
		state == LSP_READ && !$past(fall) && $past(state) == LSP_READ
		|-> $stable(sdio_out)) else $error("data changed off falling edge");
	a_write_to_control: assert property (@(posedge clk_in) disable iff (rst_in)
		state == LSP_SELECT && rise && bit_cnt == BIT_CNT_LAST && !rx_byte[SEL_DIR_BIT]
		&& rx_byte[SEL_UNIT_HI:SEL_UNIT_LO] == UNIT_MATCH |=> state == LSP_CONTROL)
		else $error("no control byte");
	a_payload_pushed: assert property (@(posedge clk_in) disable iff (rst_in || cs_n)
		state == LSP_PAYLOAD && rise && bit_cnt == BIT_CNT_LAST
		|=> push && pword.payload_target_select == $past(target))
		else $error("payload byte lost or mistargeted");
endmodule // lsp_port

/* test/lsp_host.sv */
/*
 * lsp_host: host model for the serial slave port, paced by the system clock.
 * Assumes the bench resolves the shared line from the host drive enable alone.
 */
`timescale 1ns/1ns
module lsp_host (
	input  wire logic clk_in,         // system clock, pacing only
	input  wire logic line_in,        // resolved shared data line
	input  wire logic dev_oe_n_in,    // port enable, low while port drives
	output logic      chip_sel_n_out, // chip select, active low
	output logic      sclk_out,       // serial clock, low at start, left high after each bit
	output logic      drive_out,      // host drives the line
	output logic      data_out        // value driven by the host
);
	// idle pins until the first access
	initial begin
		chip_sel_n_out = 1'b1;
		sclk_out = 1'b0;
		data_out = 1'b1;
	end
	// take the line back whenever the port lets go, so it never floats
	assign drive_out = dev_oe_n_in;
	// half a serial clock period, 400 ns
	task automatic half();
		repeat (4) @(negedge clk_in);
	endtask
	// chip select is toggled per access, never left low
	task automatic select(input logic on);
		half();
		chip_sel_n_out = ~on;
		half();
	endtask
	// n bits msb first: sample before the fall, change data on the fall
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			rx[i] = line_in;
			sclk_out = 1'b0;
			data_out = tx[i];
			half();
			sclk_out = 1'b1;
			half();
		end
	endtask
endmodule // lsp_host

/* test/lsp_port_bench.sv */
/*
 * lsp_port_bench: self-checking bench for the lcd driver serial slave port.
 * Assumes the package, the port, its buffer and test/lsp_host.sv are compiled first.
 */
`timescale 1ns/1ns
module lsp_port_bench
	import lsp_pkg::*;
;
	logic       clk_in = 1'b0;
	logic       rst_in;
	logic       cs_n, sclk, line, host_data, host_drive, sdio_val, oe_n;
	logic [7:0] temp;
	logic       valid, active, overrun;
	logic       ready;
	lsp_word_t  word;
	lsp_word_t  got[$];
	lsp_word_t  exp_q[$];
	int         err_total = 0;
	int         check_count = 0;
	int         cycles = 0;
	// -----------------------------------------------------------
	// clock, shared line, design and host
	// -----------------------------------------------------------
	always #50 clk_in = ~clk_in;
	assign line = host_drive ? host_data : sdio_val; // one party at a time
	lsp_port i_dut (
		.clk_in              (clk_in),
		.rst_in              (rst_in),
		.chip_sel_n_in       (cs_n),
		.sclk_in             (sclk),
		.sdio_in             (line),
		.sdio_out            (sdio_val),
		.sdio_oe_n_out       (oe_n),
		.temperature_byte_in (temp),
		.word_valid_out      (valid),
		.word_out            (word),
		.word_ready_in       (ready),
		.access_active_out   (active),
		.overrun_out         (overrun)
	);
	lsp_host i_host (
		.clk_in         (clk_in),
		.line_in        (line),
		.dev_oe_n_in    (oe_n),
		.chip_sel_n_out (cs_n),
		.sclk_out       (sclk),
		.drive_out      (host_drive),
		.data_out       (host_data)
	);
	// collect every word the receiver takes; cut a hang short
	always @(posedge clk_in) begin
		if (valid === 1'b1 && ready === 1'b1) got.push_back(word);
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end
	// -----------------------------------------------------------
	// compare and helper tasks
	// -----------------------------------------------------------
	task automatic chk_word(input string what, input lsp_word_t e, input lsp_word_t g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		chk_word(what, {1'b0, e}, {1'b0, g});
	endtask
	task automatic chk_flag(input string what, input logic e, input logic g);
		chk_word(what, {8'h00, e}, {8'h00, g});
	endtask
	task automatic send(input logic [7:0] b);
		logic [7:0] rx;
		i_host.shift(b, 8, rx);
	endtask
	// compare collected words against the expected list, then clear both
	task automatic match();
		chk_byte("word count", 8'(exp_q.size()), 8'(got.size()));
		for (int i = 0; i < exp_q.size() && i < got.size(); i++) chk_word("word", exp_q[i], got[i]);
		exp_q.delete();
		got.delete();
	endtask
	task automatic do_reset();
		rst_in = 1'b1;
		repeat (8) @(negedge clk_in);
		rst_in = 1'b0;
		chk_flag("oe_n at reset", 1'b1, oe_n);
		chk_flag("valid at reset", 1'b0, valid);
		chk_flag("active at reset", 1'b0, active);
		chk_flag("overrun at reset", 1'b0, overrun);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// -----------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------
	// receiver stalls: two words held, a third is dropped, then drain
	task automatic t_buffer();
		ready = 1'b0;
		i_host.select(1'b1);
		send(8'h20);
		send(8'h40);
		send(8'hab);
		send(8'h5c);
		chk_flag("active", 1'b1, active);
		chk_flag("overrun early", 1'b0, overrun);
		send(8'h33);
		i_host.select(1'b0);
		chk_flag("overrun", 1'b1, overrun);
		chk_word("oldest word", {1'b1, 8'hab}, word);
		ready = 1'b1;
		repeat (4) @(negedge clk_in);
		exp_q = '{{1'b1, 8'hab}, {1'b1, 8'h5c}};
		match();
		chk_flag("valid drained", 1'b0, valid);
		do_reset();
		$display("test buffer done");
	endtask
	// partial byte dropped on deselect, then chained control bytes
	task automatic t_chain();
		logic [7:0] rx;
		i_host.select(1'b1);
		i_host.shift(8'h20, 4, rx);
		i_host.select(1'b0);
		i_host.select(1'b1);
		send(8'h3f);
		send(8'h80);
		send(8'h12);
		send(8'h40);
		send(8'h34);
		send(8'h56);
		i_host.select(1'b0);
		exp_q = '{{1'b0, 8'h12}, {1'b1, 8'h34}, {1'b1, 8'h56}};
		match();
		$display("test chain done");
	endtask
	// every foreign unit code is ignored, for writes and a read
	task automatic t_unit();
		logic [1:0] codes [3];
		codes = '{2'h0, 2'h2, 2'h3};
		for (int i = 0; i < 3; i++) begin
			i_host.select(1'b1);
			send({1'b0, codes[i], 5'h00});
			chk_flag("active foreign", 1'b0, active);
			send(8'h40);
			send(8'h99);
			i_host.select(1'b0);
		end
		i_host.select(1'b1);
		send(8'hc0);
		repeat (2) @(negedge clk_in);
		chk_flag("oe_n foreign read", 1'b1, oe_n);
		i_host.select(1'b0);
		match();
		$display("test unit done");
	endtask
	// read twice; value latched at selection, clocks after eight ignored
	task automatic t_read();
		logic [7:0] rx;
		logic [7:0] first;
		logic [7:0] spare;
		first = 8'h00;
		for (int n = 0; n < 2; n++) begin
			temp = 8'hc5;
			i_host.select(1'b1);
			send(8'ha0);
			temp = 8'h3c;
			repeat (2) @(negedge clk_in);
			chk_flag("oe_n driving", 1'b0, oe_n);
			i_host.shift(8'h00, 8, rx);
			chk_byte("temperature", 8'hc5, rx);
			chk_flag("oe_n after eight", 1'b1, oe_n);
			i_host.shift(8'hff, 8, spare);
			chk_flag("oe_n extra clocks", 1'b1, oe_n);
			i_host.select(1'b0);
			if (n == 0) first = rx;
		end
		chk_byte("first read", 8'hc5, first);
		$display("test read done");
	endtask
	// deselect in mid read releases the line
	task automatic t_abort();
		logic [7:0] rx;
		temp = 8'h5a;
		i_host.select(1'b1);
		send(8'ha0);
		repeat (2) @(negedge clk_in);
		i_host.shift(8'h00, 3, rx);
		chk_byte("partial read", 8'h40, {rx[7:5], 5'h00});
		chk_flag("oe_n mid read", 1'b0, oe_n);
		i_host.select(1'b0);
		chk_flag("oe_n released", 1'b1, oe_n);
		$display("test abort done");
	endtask
	initial begin
		temp = 8'h00;
		ready = 1'b0;
		do_reset();
		t_buffer();
		t_chain();
		t_unit();
		t_read();
		t_abort();
		conclude();
	end
endmodule // lsp_port_bench
